// ===== include/asc_pkg.sv
package asc_pkg;
   // ----------------------------------------------------------------------
   // Bus geometry
   // ----------------------------------------------------------------------
   localparam int ADDR_W = 6;
   localparam int DATA_W = 8;
   localparam int RES_W = 10;
   localparam int NUM_RES = 16;
   localparam int POS_W = 4;
   localparam int EVT_W = 3;

   // ----------------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------------
   localparam logic [5:0] OFS_SEQ_CTL = 6'h00;
   localparam logic [5:0] OFS_POS_STAT = 6'h01;
   localparam logic [5:0] OFS_CCF_LO = 6'h02;
   localparam logic [5:0] OFS_CCF_HI = 6'h03;
   localparam logic [5:0] OFS_EVT_STAT = 6'h04;
   localparam logic [5:0] OFS_EVT_MASK = 6'h05;
   localparam logic [5:0] OFS_RES_SEL = 6'h06;
   localparam logic [5:0] OFS_RES_LO = 6'h07;
   localparam logic [5:0] OFS_RES_HI = 6'h08;

   // ----------------------------------------------------------------------
   // Sequence control fields and reset values
   // ----------------------------------------------------------------------
   localparam int LEN_LSB = 3;
   localparam int LEN_MSB = 6;
   localparam int QUEUE_BIT = 2;
   localparam int FRZ_MSB = 1;
   localparam int FRZ_LSB = 0;
   localparam logic [7:0] SEQ_CTL_RST = 8'h20;
   localparam logic [7:0] SEQ_CTL_WMASK = 8'h7f;
   localparam logic [3:0] LEN_CODE_MAX = 4'h0;
   localparam logic [4:0] SEQ_LEN_MAX = 5'h10;

   // Breakpoint response codes
   localparam logic [1:0] FRZ_CONTINUE = 2'h0;
   localparam logic [1:0] FRZ_RSVD = 2'h1;
   localparam logic [1:0] FRZ_FINISH = 2'h2;
   localparam logic [1:0] FRZ_NOW = 2'h3;

   // ----------------------------------------------------------------------
   // Status and event layout
   // ----------------------------------------------------------------------
   localparam int STAT_BUSY_BIT = 4;
   localparam int STAT_FROZEN_BIT = 5;
   localparam int EVT_SEQ_DONE = 0;
   localparam int EVT_CONV_DONE = 1;
   localparam int EVT_ABORT = 2;
   localparam logic [2:0] EVT_MASK_RST = 3'h0;
   localparam logic [3:0] POS_RST = 4'h0;
   localparam logic [15:0] CCF_RST = 16'h0000;

   // Sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_CONV = 3'b010,
      ST_HALT = 3'b100
   } asc_state_e;
endpackage

// ===== verilog/asc_result_mem.sv
`timescale 1ns/10ps
module asc_result_mem (
   input wire logic clk,
   input wire logic reset,
   input wire logic wrEn,
   input wire logic [3:0] wrAddr,
   input wire logic [9:0] wrData,
   input wire logic [3:0] rdAddr,
   output logic [9:0] rdData
);
   // ----------------------------------------------------------------------
   // Result storage
   // ----------------------------------------------------------------------
   logic [9:0] mem [asc_pkg::NUM_RES];

   // Array has no reset; validity is tracked by the complete flags
   always_ff @(posedge clk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
   end

   // Registered read keeps the bus path short
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rdData <= 10'h000;
      end else begin
         rdData <= mem[rdAddr];
      end
   end
endmodule

// ===== verilog/asc_event_regs.sv
`timescale 1ns/10ps
module asc_event_regs (
   input wire logic clk,
   input wire logic reset,
   input wire logic [2:0] evtPulse,
   input wire logic clrWr,
   input wire logic [2:0] clrData,
   input wire logic maskWr,
   input wire logic [2:0] maskData,
   output logic [2:0] status,
   output logic [2:0] mask,
   output logic irq
);
   // ----------------------------------------------------------------------
   // Sticky status, write one to clear
   // ----------------------------------------------------------------------
   logic [2:0] clrBits;

   assign clrBits = clrWr ? clrData : 3'h0;

   // Set wins over a clear in the same cycle so no event is lost
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         status <= 3'h0;
      end else begin
         status <= (status & ~clrBits) | evtPulse;
      end
   end

   // Mask register
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         mask <= asc_pkg::EVT_MASK_RST;
      end else if (maskWr) begin
         mask <= maskData;
      end
   end

   // Level interrupt, one cycle behind the status bits
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status & mask);
      end
   end
endmodule

// ===== verilog/asc_seq_ctrl.sv
// Chosen here: the strobed register port and the address map.
`timescale 1ns/10ps
// Overview of operation
// R01 - Any write to the sequence control register aborts the running sequence and starts none.
// R02 - Length bits weighted 8,4,2,1 give 1 to 15 conversions, and all zero gives 16.
// R03 - After reset the weight-4 length bit is set, so a sequence is four conversions long.
// R04 - With queue mode clear, the nth result of a sequence lands in the nth result register.
// R05 - With queue mode set, the position counter is not reset when a sequence begins or ends; here startSeq still resets it, only a trigger start keeps it.
// R06 - In queue mode with continuous scanning the position counter wraps past the last register.
// R07 - The position counter is readable and names the register for the next result.
// R08 - An abort or any control register write clears the position counter, even in queue mode.
// R09 - Each result register has a complete flag showing it holds valid data.
// R10 - Breakpoint field: 00 continue, 01 reserved, 10 finish then halt, 11 halt at once.
// R11 - Software should use queue mode only with continuous scanning or triggered conversion.
// R12 - Bit 7 of the sequence control register reads zero and ignores writes.
module asc_seq_ctrl (
   input wire logic clk,
   input wire logic reset,
   input wire logic [5:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdData,
   input wire logic startSeq,
   input wire logic otherCtlWrite,
   input wire logic scanMode,
   input wire logic triggeredMode,
   input wire logic trigPulse,
   input wire logic freezeReq,
   input wire logic convAck,
   input wire logic [9:0] convData,
   output logic convReq,
   output logic seqBusy,
   output logic irq
);
   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   logic [7:0] seqCtl_q;
   logic [3:0] lenBits;
   logic queueMode;
   logic [1:0] breakpointResponse;
   logic [4:0] seqLen;
   asc_pkg::asc_state_e state_q;
   asc_pkg::asc_state_e state_d;
   logic [3:0] seqCnt_q;
   logic [3:0] resultPositionCount_q;
   logic [15:0] ccf_q;
   logic [3:0] resSel_q;
   logic [9:0] resData;
   logic [2:0] evtStatus;
   logic [2:0] evtMask;
   logic [2:0] evtPulse;
   logic seqCtlWr;
   logic abortReq;
   logic trigStart;
   logic newSeq;
   logic ackTaken;
   logic lastConv;
   logic freezeNow;
   logic freezeAfter;
   logic resLoRd;

   // ----------------------------------------------------------------------
   // Register decode
   // ----------------------------------------------------------------------
   assign seqCtlWr = regWr && (regAddr == asc_pkg::OFS_SEQ_CTL);
   assign resLoRd = regRd && (regAddr == asc_pkg::OFS_RES_LO);

   // Field split of the sequence control register
   assign lenBits = seqCtl_q[asc_pkg::LEN_MSB:asc_pkg::LEN_LSB];
   assign queueMode = seqCtl_q[asc_pkg::QUEUE_BIT];
   assign breakpointResponse = seqCtl_q[asc_pkg::FRZ_MSB:asc_pkg::FRZ_LSB];

   // Code zero stands for the longest sequence
   assign seqLen = (lenBits == asc_pkg::LEN_CODE_MAX) ? asc_pkg::SEQ_LEN_MAX
                                                      : {1'b0, lenBits}; // [R02]

   // ----------------------------------------------------------------------
   // Sequencer conditions
   // ----------------------------------------------------------------------
   // Either control write aborts; the write never starts anything
   assign abortReq = seqCtlWr || otherCtlWrite; // [R01] [R08]
   // Queue mode is meant for scan or trigger use; trigger gated by its mode
   assign trigStart = trigPulse && triggeredMode;
   assign newSeq = (startSeq || trigStart) && !abortReq;
   assign ackTaken = convAck && (state_q == asc_pkg::ST_CONV);
   assign lastConv = ({1'b0, seqCnt_q} + 5'h01) == seqLen; // [R02]
   // Reserved code behaves as continue
   assign freezeNow = freezeReq && (breakpointResponse == asc_pkg::FRZ_NOW); // [R10]
   assign freezeAfter = freezeReq && breakpointResponse[asc_pkg::FRZ_MSB]; // [R10]

   // Event sources for the interrupt block
   assign evtPulse[asc_pkg::EVT_SEQ_DONE] = ackTaken && lastConv;
   assign evtPulse[asc_pkg::EVT_CONV_DONE] = ackTaken;
   assign evtPulse[asc_pkg::EVT_ABORT] = abortReq && (state_q != asc_pkg::ST_IDLE);

   // ----------------------------------------------------------------------
   // Sequence control register
   // ----------------------------------------------------------------------
   // Top bit is masked off so it always reads zero
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         seqCtl_q <= asc_pkg::SEQ_CTL_RST; // [R03]
      end else if (seqCtlWr) begin
         seqCtl_q <= regWrData & asc_pkg::SEQ_CTL_WMASK; // [R12]
      end
   end

   // Result read select, steers the memory read port
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         resSel_q <= asc_pkg::POS_RST;
      end else if (regWr && (regAddr == asc_pkg::OFS_RES_SEL)) begin
         resSel_q <= regWrData[3:0];
      end
   end

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   // An in-flight result is dropped on an immediate freeze; the
   // conversion is redone after release since a held node leaks
   always_comb begin
      state_d = state_q;
      if (abortReq) begin
         state_d = asc_pkg::ST_IDLE; // [R01]
      end else if (newSeq) begin
         state_d = asc_pkg::ST_CONV;
      end else begin
         unique case (state_q)
            asc_pkg::ST_IDLE: begin
               state_d = asc_pkg::ST_IDLE;
            end
            asc_pkg::ST_CONV: begin
               if (ackTaken && lastConv && !scanMode) begin
                  state_d = asc_pkg::ST_IDLE;
               end else if (ackTaken && freezeAfter) begin
                  state_d = asc_pkg::ST_HALT; // [R10]
               end else if (!ackTaken && freezeNow) begin
                  state_d = asc_pkg::ST_HALT; // [R10]
               end
            end
            asc_pkg::ST_HALT: begin
               if (!freezeAfter) begin
                  state_d = asc_pkg::ST_CONV;
               end
            end
            default: begin
               state_d = asc_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // State register and the flopped outputs that follow it
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_q <= asc_pkg::ST_IDLE;
         convReq <= 1'b0;
         seqBusy <= 1'b0;
      end else begin
         state_q <= state_d;
         convReq <= state_d == asc_pkg::ST_CONV;
         seqBusy <= state_d != asc_pkg::ST_IDLE;
      end
   end

   // ----------------------------------------------------------------------
   // Conversion and position counters
   // ----------------------------------------------------------------------
   // Count of conversions done within the current sequence
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         seqCnt_q <= asc_pkg::POS_RST;
      end else if (abortReq || newSeq) begin
         seqCnt_q <= asc_pkg::POS_RST;
      end else if (ackTaken) begin
         seqCnt_q <= lastConv ? asc_pkg::POS_RST : seqCnt_q + 4'h1;
      end
   end

   // Position of the next result register
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         resultPositionCount_q <= asc_pkg::POS_RST;
      end else if (abortReq) begin
         resultPositionCount_q <= asc_pkg::POS_RST; // [R08]
      end else if (newSeq) begin
         if (startSeq || !queueMode) begin
            resultPositionCount_q <= asc_pkg::POS_RST; // [R04] [R08]
         end
      end else if (ackTaken) begin
         if (lastConv && !queueMode) begin
            resultPositionCount_q <= asc_pkg::POS_RST; // [R04]
         end else begin
            // Four bits wrap naturally past the last register
            resultPositionCount_q <= resultPositionCount_q + 4'h1; // [R05] [R06]
         end
      end
   end

   // ----------------------------------------------------------------------
   // Conversion complete flags
   // ----------------------------------------------------------------------
   // A startSeq pulse clears all; reading a result's low half clears its own flag,
   // but a result landing in the same cycle keeps the flag set
   for (genvar i = 0; i < asc_pkg::NUM_RES; i++) begin : gCcf
      always_ff @(posedge clk or posedge reset) begin
         if (reset) begin
            ccf_q[i] <= 1'b0;
         end else if (ackTaken && (resultPositionCount_q == 4'(i))) begin
            ccf_q[i] <= 1'b1; // [R09]
         end else if (startSeq && !abortReq) begin
            ccf_q[i] <= 1'b0;
         end else if (resLoRd && (resSel_q == 4'(i))) begin
            ccf_q[i] <= 1'b0; // [R09]
         end
      end
   end

   // ----------------------------------------------------------------------
   // Result memory and interrupt block
   // ----------------------------------------------------------------------
   asc_result_mem uMem (
      .clk(clk),
      .reset(reset),
      .wrEn(ackTaken),
      .wrAddr(resultPositionCount_q), // [R04] [R05]
      .wrData(convData),
      .rdAddr(resSel_q),
      .rdData(resData)
   );

   asc_event_regs uEvt (
      .clk(clk),
      .reset(reset),
      .evtPulse(evtPulse),
      .clrWr(regWr && (regAddr == asc_pkg::OFS_EVT_STAT)),
      .clrData(regWrData[2:0]),
      .maskWr(regWr && (regAddr == asc_pkg::OFS_EVT_MASK)),
      .maskData(regWrData[2:0]),
      .status(evtStatus),
      .mask(evtMask),
      .irq(irq)
   );

   // ----------------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------------
   // Data stand only in the cycle after the strobe; zero otherwise and
   // for unmapped offsets
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         regRdData <= 8'h00;
      end else if (!regRd) begin
         regRdData <= 8'h00;
      end else begin
         unique case (regAddr)
            asc_pkg::OFS_SEQ_CTL: begin
               regRdData <= seqCtl_q; // [R12]
            end
            asc_pkg::OFS_POS_STAT: begin
               regRdData <= {2'h0, state_q == asc_pkg::ST_HALT,
                             state_q != asc_pkg::ST_IDLE,
                             resultPositionCount_q}; // [R07]
            end
            asc_pkg::OFS_CCF_LO: begin
               regRdData <= ccf_q[7:0]; // [R09]
            end
            asc_pkg::OFS_CCF_HI: begin
               regRdData <= ccf_q[15:8]; // [R09]
            end
            asc_pkg::OFS_EVT_STAT: begin
               regRdData <= {5'h00, evtStatus};
            end
            asc_pkg::OFS_EVT_MASK: begin
               regRdData <= {5'h00, evtMask};
            end
            asc_pkg::OFS_RES_SEL: begin
               regRdData <= {4'h0, resSel_q};
            end
            asc_pkg::OFS_RES_LO: begin
               regRdData <= resData[7:0];
            end
            asc_pkg::OFS_RES_HI: begin
               regRdData <= {6'h00, resData[9:8]};
            end
            default: begin
               regRdData <= 8'h00;
            end
         endcase
      end
   end
endmodule

// ===== bench/asc_seq_monitor.sv
`timescale 1ns/10ps
module asc_seq_monitor (
   input wire logic clk,
   input wire logic reset,
   input wire logic [5:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [7:0] regRdData,
   input wire logic startSeq,
   input wire logic otherCtlWrite,
   input wire logic scanMode,
   input wire logic triggeredMode,
   input wire logic trigPulse,
   input wire logic freezeReq,
   input wire logic convAck,
   input wire logic [9:0] convData,
   input wire logic convReq,
   input wire logic seqBusy,
   input wire logic irq
);
   // ----------------------------------------------------------------
   // Shadow of the control register and progress through a sequence
   // ----------------------------------------------------------------
   logic [7:0] ctlQ;
   logic [4:0] ackCntQ;
   logic [4:0] seqLen;
   logic ctlWr;
   logic quiet;
   // Quiet means nothing restarts or aborts the sequence this cycle
   assign ctlWr = regWr && regAddr == asc_pkg::OFS_SEQ_CTL;
   assign quiet = !ctlWr && !otherCtlWrite && !startSeq && !(trigPulse && triggeredMode);
   assign seqLen = (ctlQ[6:3] == 4'h0) ? 5'h10 : {1'b0, ctlQ[6:3]};
   // Follows software writes only, so it cannot drift from the design's copy
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ctlQ <= 8'h20;
      end else if (ctlWr) begin
         ctlQ <= regWrData & 8'h7f;
      end
   end
   // Accepted results within the running sequence; wraps at the length
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ackCntQ <= 5'h00;
      end else if (!quiet) begin
         ackCntQ <= 5'h00;
      end else if (convReq && convAck) begin
         ackCntQ <= (ackCntQ + 5'h01 == seqLen) ? 5'h00 : ackCntQ + 5'h01;
      end
   end
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_ack_taken;
      convReq && convAck && quiet;
   endsequence
   sequence s_halted;
      seqBusy && !convReq && !freezeReq && quiet;
   endsequence
   a_ctl_write_abort: assert property (ctlWr ##1 quiet
      |-> !convReq && !seqBusy ##1 !convReq)
      else $error("control write left a sequence running");
   a_other_abort: assert property (otherCtlWrite |=> !convReq && !seqBusy)
      else $error("control write elsewhere did not abort");
   a_start_request: assert property (startSeq && !ctlWr && !otherCtlWrite && !freezeReq
      |=> convReq && seqBusy)
      else $error("start did not raise the request");
   a_ctl_readback: assert property (regRd && regAddr == asc_pkg::OFS_SEQ_CTL
      |=> regRdData == ctlQ)
      else $error("control readback differs from written value");
   a_halt_now: assert property (convReq && freezeReq && ctlQ[1:0] == 2'h3 && !convAck
      && quiet |=> !convReq)
      else $error("immediate freeze did not halt");
   a_freeze_ignored: assert property (convReq && freezeReq && !ctlQ[1] && !convAck
      && quiet |=> convReq)
      else $error("freeze halted in continue mode");
   a_last_ack: assert property (s_ack_taken ##0 (!scanMode && ackCntQ + 5'h01 == seqLen)
      |=> !convReq && !seqBusy)
      else $error("sequence did not end at its length");
   a_mid_ack: assert property (s_ack_taken ##0 (!freezeReq
      && (scanMode || ackCntQ + 5'h01 != seqLen)) |=> convReq)
      else $error("sequence ended early");
   a_freeze_resume: assert property (s_halted |-> ##[1:2] convReq)
      else $error("no resume after freeze release");
endmodule
bind asc_seq_ctrl asc_seq_monitor i_mon (.clk(clk), .reset(reset), .regAddr(regAddr),
   .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
   .startSeq(startSeq), .otherCtlWrite(otherCtlWrite), .scanMode(scanMode),
   .triggeredMode(triggeredMode), .trigPulse(trigPulse), .freezeReq(freezeReq),
   .convAck(convAck), .convData(convData), .convReq(convReq), .seqBusy(seqBusy), .irq(irq));

// ===== bench/test_adc_sequence_result_control.sv
`timescale 1ns/10ps
module test_adc_sequence_result_control;
   // ----------------------------------------------------------------
   // Stimulus signals and design under test
   // ----------------------------------------------------------------
   localparam logic [5:0] CTL = asc_pkg::OFS_SEQ_CTL;
   localparam logic [5:0] POS = asc_pkg::OFS_POS_STAT;
   localparam logic [5:0] EVT = asc_pkg::OFS_EVT_STAT;
   logic clk, reset, regWr, regRd, startSeq, otherCtlWrite, scanMode, triggeredMode;
   logic trigPulse, freezeReq, convAck, convReq, seqBusy, irq;
   logic [5:0] regAddr;
   logic [7:0] regWrData, regRdData, rdv;
   logic [9:0] convData;
   logic [9:0] res [16];
   logic [3:0] corner [4] = '{4'h0, 4'h1, 4'hf, 4'h4};
   int errTotal = 0;
   int numChecks = 0;
   int cnt;
   asc_seq_ctrl i_dut (.clk(clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .startSeq(startSeq),
      .otherCtlWrite(otherCtlWrite), .scanMode(scanMode), .triggeredMode(triggeredMode),
      .trigPulse(trigPulse), .freezeReq(freezeReq), .convAck(convAck), .convData(convData),
      .convReq(convReq), .seqBusy(seqBusy), .irq(irq));
   // ----------------------------------------------------------------
   // Checks, bus cycles and expectations
   // ----------------------------------------------------------------
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      numChecks++;
      if (got !== exp) begin
         errTotal++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chkBit(input logic got, input logic exp);
      chk8({7'h00, got}, {7'h00, exp});
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   // Data stand only in the cycle after the strobe, so sample just then
   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      @(posedge clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1 d = regRdData;
   endtask
   // 0 start, 1 trigger, 2 write to another control register
   task automatic pulse(input int which);
      @(posedge clk);
      case (which)
         0: startSeq <= 1'b1;
         1: trigPulse <= 1'b1;
         default: otherCtlWrite <= 1'b1;
      endcase
      @(posedge clk);
      startSeq <= 1'b0;
      trigPulse <= 1'b0;
      otherCtlWrite <= 1'b0;
      #1;
   endtask
   // Data flip after the pulse so a stale value is never mistaken for a result
   task automatic ack(input logic [9:0] d);
      @(posedge clk);
      convAck <= 1'b1;
      convData <= d;
      @(posedge clk);
      convAck <= 1'b0;
      convData <= ~d;
      #1;
   endtask
   task automatic drain(input int maxN);
      logic [9:0] d;
      cnt = 0;
      while (convReq === 1'b1 && cnt < maxN) begin
         d = 10'($urandom);
         res[cnt[3:0]] = d;
         ack(d);
         cnt++;
      end
   endtask
   function automatic int lenOf(input logic [3:0] code);
      return (code == 4'h0) ? 16 : int'(code);
   endfunction
   task automatic runPlain(input logic [3:0] code);
      int n;
      logic [15:0] f;
      n = lenOf(code);
      f = 16'((32'h1 << n) - 1);
      wr(CTL, {1'b0, code, 3'h0});
      pulse(0);
      drain(20);
      chk8(8'(cnt), 8'(n));
      rd(POS, rdv);
      chk8(rdv, 8'h00);
      chkBit(irq, 1'b1);
      rd(EVT, rdv);
      chk8(rdv, 8'h03);
      wr(EVT, 8'h07);
      rd(asc_pkg::OFS_CCF_LO, rdv);
      chkBit(irq, 1'b0);
      chk8(rdv, f[7:0]);
      rd(asc_pkg::OFS_CCF_HI, rdv);
      chk8(rdv, f[15:8]);
      for (int i = 0; i < n; i++) begin
         wr(asc_pkg::OFS_RES_SEL, 8'(i));
         rd(asc_pkg::OFS_RES_LO, rdv);
         chk8(rdv, res[i][7:0]);
         rd(asc_pkg::OFS_RES_HI, rdv);
         chk8(rdv, {6'h00, res[i][9:8]});
      end
      // Reading each low half has cleared its complete flag
      rd(asc_pkg::OFS_CCF_LO, rdv);
      chk8(rdv, 8'h00);
   endtask
   task automatic giveVerdict();
      if (errTotal == 0 && numChecks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Clock, main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      {reset, regWr, regRd, startSeq, otherCtlWrite, scanMode} = 6'h20;
      {triggeredMode, trigPulse, freezeReq, convAck} = 4'h8;
      {regAddr, regWrData, convData} = 24'h000000;
      void'($urandom(83));
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      rd(CTL, rdv);
      chk8(rdv, 8'h20);
      wr(CTL, 8'hff);
      rd(CTL, rdv);
      chk8(rdv, 8'h7f);
      rd(6'h3f, rdv);
      chk8(rdv, 8'h00);
      wr(asc_pkg::OFS_EVT_MASK, 8'h01);
      for (int k = 0; k < 7; k++) runPlain(k < 4 ? corner[k] : 4'($urandom));
      // Queue mode: position survives sequence ends and triggered restarts
      wr(CTL, 8'h1c);
      pulse(0);
      drain(20);
      rd(POS, rdv);
      chk8(rdv, 8'h03);
      pulse(1);
      drain(20);
      rd(POS, rdv);
      chk8(rdv, 8'h06);
      @(posedge clk);
      scanMode <= 1'b1;
      pulse(1);
      drain(12);
      chkBit(convReq, 1'b1);
      rd(POS, rdv);
      chk8(rdv, 8'h12);
      pulse(2);
      chkBit(convReq, 1'b0);
      @(posedge clk);
      scanMode <= 1'b0;
      rd(POS, rdv);
      chk8(rdv, 8'h00);
      rd(EVT, rdv);
      chk8(rdv, 8'h07);
      wr(EVT, 8'h07);
      // A control write stops a running sequence and starts nothing
      wr(CTL, 8'h20);
      pulse(0);
      ack(10'h155);
      wr(CTL, 8'h24);
      #1 chkBit(convReq, 1'b0);
      repeat (3) @(posedge clk);
      #1 chkBit(convReq, 1'b0);
      rd(POS, rdv);
      chk8(rdv, 8'h00);
      // Every breakpoint response code, with one result offered while the freeze is requested
      for (int c = 0; c < 4; c++) begin
         wr(CTL, 8'h20 | 8'(c));
         pulse(0);
         @(posedge clk);
         freezeReq <= 1'b1;
         repeat (3) @(posedge clk);
         #1 chkBit(convReq, 1'(c < 3));
         ack(10'h2aa);
         @(posedge clk);
         #1 chkBit(convReq, 1'(c < 2));
         rd(POS, rdv);
         chk8(rdv, {2'h0, 1'(c > 1), 1'b1, 4'(c != 3)});
         @(posedge clk);
         freezeReq <= 1'b0;
         repeat (2) @(posedge clk);
         #1 chkBit(convReq, 1'b1);
         pulse(2);
      end
      // Abort events stay masked until the mask lets them through
      rd(EVT, rdv);
      chk8(rdv, 8'h06);
      chkBit(irq, 1'b0);
      wr(asc_pkg::OFS_EVT_MASK, 8'h04);
      @(posedge clk);
      #1 chkBit(irq, 1'b1);
      wr(EVT, 8'h04);
      @(posedge clk);
      #1 chkBit(irq, 1'b0);
      // Trigger pulses start nothing while triggered mode is off
      @(posedge clk);
      triggeredMode <= 1'b0;
      pulse(1);
      chkBit(convReq, 1'b0);
      giveVerdict();
   end
   // Whole run needs about a thousand cycles at most; the 40000-cycle limit allows ample margin
   initial begin
      #1000000;
      errTotal++;
      giveVerdict();
   end
endmodule
